// ==== inc/irq_pkg.sv ====
package irq_pkg;

	// Source count and bus geometry
	localparam int          NUM_SRC   = 15;
	localparam int          ADDR_W    = 12;
	localparam int          DATA_W    = 32;

	// Register byte offsets
	localparam logic [11:0] OFS_ENABLE_PRIMARY = 12'h0A8;
	localparam logic [11:0] OFS_ENABLE_T2      = 12'h0E8;
	localparam logic [11:0] OFS_PRIO_PRIMARY   = 12'h0B8;
	localparam logic [11:0] OFS_PRIO_T2        = 12'h0F8;
	localparam logic [11:0] OFS_PIN_CFG        = 12'h000;
	localparam logic [11:0] OFS_STATUS         = 12'h004;

	// Reset values
	localparam logic [7:0]  RST_ENABLE  = 8'h00;
	localparam logic [7:0]  RST_PRIO    = 8'h00;
	localparam logic [11:0] RST_PIN_CFG = 12'h000;

	// Field positions
	localparam int GLOBAL_ALLOW_BIT  = 7;
	localparam int CFG_PIN_A_TRANS   = 0;
	localparam int CFG_PIN_B_TRANS   = 1;
	localparam int CFG_CAP_PINS_IRQ  = 2;
	localparam int CFG_CAP_SEL_LSB   = 4;
	localparam int CFG_W             = 12;
	localparam int STAT_LO_ACTIVE    = 16;
	localparam int STAT_HI_ACTIVE    = 17;
	localparam int STAT_LATE         = 18;

	// Service-order indices of the sources holding pin-latched flags
	localparam int SRC_PIN_A = 0;
	localparam int SRC_CAP0  = 4;
	localparam int SRC_PIN_B = 6;
	localparam int SRC_CAP1  = 7;
	localparam int SRC_CAP2  = 10;
	localparam int SRC_CAP3  = 13;

	// Per source, in service order: {register, bit} of enable and priority
	localparam logic [3:0] SRC_BIT [NUM_SRC] = '{
		4'h0, 4'h5, 4'h6, 4'h1, 4'h8, 4'hC, 4'h2, 4'h9,
		4'hD, 4'h3, 4'hA, 4'hE, 4'h4, 4'hB, 4'hF};
	// Per source, in service order: vector slot number
	localparam logic [3:0] SRC_VEC [NUM_SRC] = '{
		4'h0, 4'h5, 4'hA, 4'h1, 4'h6, 4'hB, 4'h2, 4'h7,
		4'hC, 4'h3, 4'h8, 4'hD, 4'h4, 4'h9, 4'hE};

	// Vector addresses
	localparam logic [15:0] VEC_BASE  = 16'h0003;
	localparam int          VEC_SHIFT = 3;

	// Response latency at the core clock
	localparam int CLK_PERIOD_NS = 8;
	localparam int LAT_MIN_NS    = 2250;
	localparam int LAT_MAX_NS    = 7500;
	localparam int LAT_MIN_CYC   = (LAT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LAT_MAX_CYC   = LAT_MAX_NS / CLK_PERIOD_NS;
	localparam int LAT_W         = 10;

	// Pin sensing modes
	typedef enum logic [1:0] {EDGE_NONE, EDGE_RISE, EDGE_FALL, EDGE_BOTH} edge_sel_t;

	// Request presented to the core
	typedef struct packed {
		logic        req;
		logic        high_level;
		logic [15:0] vector;
	} cpu_irq_t;

endpackage : irq_pkg

// ==== src/irq_pin_sense.sv ====
`timescale 1ns/1ns
module irq_pin_sense
	import irq_pkg::*;
(
	// Clock and reset
	input  wire logic      pclk,
	input  wire logic      presetn,
	// Pin and mode
	input  wire logic      pin,
	input  wire edge_sel_t sel,
	// Sensed pin
	output logic           level,
	output logic           event_pulse
);

	logic meta_q;
	logic sync_q;
	logic prev_q;

	// Two-stage synchroniser plus prev_q for edges; meta_q is never looked at
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
			prev_q <= 1'b1;
		end else begin
			meta_q <= pin;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level = sync_q;

	// Edge decode by selected mode
	always_comb begin
		unique case (sel)
			EDGE_NONE: event_pulse = 1'b0;
			EDGE_RISE: event_pulse = sync_q & ~prev_q;
			EDGE_FALL: event_pulse = ~sync_q & prev_q;
			EDGE_BOTH: event_pulse = sync_q ^ prev_q;
		endcase
	end

endmodule : irq_pin_sense

// ==== src/two_level_irq_controller.sv ====
`timescale 1ns/1ns
// Behaviour
// - Fifteen request sources: two pins, two timers, eight timer-2 events, ADC, CAN, UART.
// - Nested scheme with exactly two priority levels.
// - No request is accepted while a CAN DMA transfer runs.
// - Timer 2 gives four capture, three compare and one overflow request.
// - Unused capture pins act as extra interrupts on rising, falling or both edges.
// - Capture-pin requests never end idle mode.
// - Every source has its own program-memory vector.
// - Every source has its own enable bit in one of two enable registers.
// - Every source has its own level bit in one of two priority registers.
// - Bit 7 of first enable register globally allows or blocks all requests.
// - Both external pins trigger on active level or on transition.
// - First enable register at A8H: ADC, CAN, UART, T1, ext1, T0, ext0.
// - Second enable register at E8H: T2 overflow, compare 2-0, capture 3-0.
// - In second enable register 0 disables, 1 enables.
// - Request to routine start takes between 2.25 us and 7.5 us.
// - Simultaneous high and low requests: high one is vectored.
// - Equal level requests served in fixed order starting ext0, CAN, ADC.
// - Low routine preempted only by high; high routine never preempted.
// - Vectors start at 0003H and step eight bytes up to 0073H.
module two_level_irq_controller
	import irq_pkg::*;
(
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic                   pready,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pslverr,
	// External pins; interrupt pins active low, capture pins on programmed edges
	input  wire logic              pin_irq_a_n,
	input  wire logic              pin_irq_b_n,
	input  wire logic [3:0]        capture_input_pins,
	// On-chip peripheral requests
	input  wire logic              timer_a_irq,
	input  wire logic              timer_b_irq,
	input  wire logic [3:0]        capture_irq,
	input  wire logic [2:0]        compare_irq,
	input  wire logic              timer_c_overflow_irq,
	input  wire logic              adc_done_irq,
	input  wire logic              can_port_irq,
	input  wire logic              uart_port_irq,
	// System state
	input  wire logic              can_dma_busy,
	input  wire logic              idle_mode,
	output logic                   idle_wake,
	// Core handshake
	output cpu_irq_t               cpu_irq,
	input  wire logic              cpu_irq_ack,
	input  wire logic              cpu_irq_return
);

	logic [7:0]         enable_prim_q;
	logic [7:0]         enable_t2_q;
	logic [7:0]         prio_prim_q;
	logic [7:0]         prio_t2_q;
	logic [CFG_W-1:0]   pin_cfg_q;
	logic [5:0]         pin_flag_q;
	logic               hi_active_q;
	logic               lo_active_q;
	logic               late_q;
	logic [3:0]         cand_idx_q;
	logic               cand_hi_q;
	logic               cand_valid_q;
	logic [LAT_W-1:0]   wait_q;
	logic [DATA_W-1:0]  prdata_q;
	logic               slverr_q;
	logic               idle_wake_q;
	logic [15:0]        vector_q;
	logic               pin_a_lvl;
	logic               pin_b_lvl;
	logic [5:0]         pin_evt;
	logic [NUM_SRC-1:0] src_req;
	logic [NUM_SRC-1:0] wake_req;
	logic [NUM_SRC-1:0] en_src;
	logic [NUM_SRC-1:0] hi_src;
	logic [15:0]        en_all;
	logic [15:0]        hi_all;
	logic [NUM_SRC-1:0] hi_pend;
	logic [NUM_SRC-1:0] lo_pend;
	logic               allow;
	logic [3:0]         pick_idx;
	logic               pick_hi;
	logic               pick_valid;
	logic               req;
	logic               take;
	logic               wr_en;
	logic               setup;

	// Lowest set bit wins: service order is encoded by index
	function automatic logic [4:0] first_set(input logic [NUM_SRC-1:0] v);
		logic [4:0] r;
		r = 5'h1F;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b0, 4'(i)};
			end
		end
		return r;
	endfunction : first_set

	// Pin-flag slot of a source, or 7 when the source has none
	function automatic logic [2:0] flag_slot(input logic [3:0] idx);
		unique case (idx)
			4'(SRC_PIN_A): flag_slot = 3'h0;
			4'(SRC_PIN_B): flag_slot = 3'h1;
			4'(SRC_CAP0):  flag_slot = 3'h2;
			4'(SRC_CAP1):  flag_slot = 3'h3;
			4'(SRC_CAP2):  flag_slot = 3'h4;
			4'(SRC_CAP3):  flag_slot = 3'h5;
			default:       flag_slot = 3'h7;
		endcase
	endfunction : flag_slot

	// Address decode used by the read path for the error response
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		return (a == OFS_ENABLE_PRIMARY) || (a == OFS_ENABLE_T2) || (a == OFS_PRIO_PRIMARY) ||
			(a == OFS_PRIO_T2) || (a == OFS_PIN_CFG) || (a == OFS_STATUS);
	endfunction : mapped

	// External pins: falling edge for transition mode, level kept for level mode
	irq_pin_sense u_pin_a (
		.pclk        (pclk),
		.presetn     (presetn),
		.pin         (pin_irq_a_n),
		.sel         (EDGE_FALL),
		.level       (pin_a_lvl),
		.event_pulse (pin_evt[0])
	);

	irq_pin_sense u_pin_b (
		.pclk        (pclk),
		.presetn     (presetn),
		.pin         (pin_irq_b_n),
		.sel         (EDGE_FALL),
		.level       (pin_b_lvl),
		.event_pulse (pin_evt[1])
	);

	// Capture pins sensed on the programmed edges
	for (genvar g = 0; g < 4; g++) begin : g_cap_pin
		irq_pin_sense u_cap (
			.pclk        (pclk),
			.presetn     (presetn),
			.pin         (capture_input_pins[g]),
			.sel         (edge_sel_t'(pin_cfg_q[CFG_CAP_SEL_LSB + 2*g +: 2])),
			.level       (),
			.event_pulse (pin_evt[g+2])
		);
	end

	assign pready = 1'b1;
	assign setup  = psel & ~penable;
	assign wr_en  = psel & penable & pwrite;

	// Software-written registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_prim_q <= RST_ENABLE;
			enable_t2_q   <= RST_ENABLE;
			prio_prim_q   <= RST_PRIO;
			prio_t2_q     <= RST_PRIO;
			pin_cfg_q     <= RST_PIN_CFG;
		end else if (wr_en) begin
			unique case (paddr)
				OFS_ENABLE_PRIMARY: enable_prim_q <= pwdata[7:0];
				OFS_ENABLE_T2:      enable_t2_q   <= pwdata[7:0];
				OFS_PRIO_PRIMARY:   prio_prim_q   <= {1'b0, pwdata[6:0]};
				OFS_PRIO_T2:        prio_t2_q     <= pwdata[7:0];
				OFS_PIN_CFG:        pin_cfg_q     <= pwdata[CFG_W-1:0];
				default:            ;
			endcase
		end
	end

	// Read data latched in the setup phase, so access phase has flop-driven data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
			slverr_q <= 1'b0;
		end else if (setup) begin
			slverr_q <= ~mapped(paddr);
			unique case (paddr)
				OFS_ENABLE_PRIMARY: prdata_q <= {24'h000000, enable_prim_q};
				OFS_ENABLE_T2:      prdata_q <= {24'h000000, enable_t2_q};
				OFS_PRIO_PRIMARY:   prdata_q <= {24'h000000, prio_prim_q};
				OFS_PRIO_T2:        prdata_q <= {24'h000000, prio_t2_q};
				OFS_PIN_CFG:        prdata_q <= {20'h00000, pin_cfg_q};
				OFS_STATUS:         prdata_q <= {13'h0000, late_q, hi_active_q, lo_active_q, 1'b0, src_req};
				default:            prdata_q <= '0;
			endcase
		end
	end

	assign prdata  = prdata_q;
	assign pslverr = slverr_q & psel & penable;

	// Raw requests in service order; capture flags OR'd with timer events
	assign src_req = {timer_c_overflow_irq,
		capture_irq[3] | pin_flag_q[5], uart_port_irq,
		compare_irq[2], capture_irq[2] | pin_flag_q[4], timer_b_irq,
		compare_irq[1], capture_irq[1] | pin_flag_q[3],
		pin_cfg_q[CFG_PIN_B_TRANS] ? pin_flag_q[1] : ~pin_b_lvl,
		compare_irq[0], capture_irq[0] | pin_flag_q[2], timer_a_irq,
		adc_done_irq, can_port_irq,
		pin_cfg_q[CFG_PIN_A_TRANS] ? pin_flag_q[0] : ~pin_a_lvl};

	// Wake set leaves capture-pin flags out, timer 2 being halted in idle
	assign wake_req = {timer_c_overflow_irq, capture_irq[3], uart_port_irq,
		compare_irq[2], capture_irq[2], timer_b_irq, compare_irq[1], capture_irq[1],
		src_req[SRC_PIN_B], compare_irq[0], capture_irq[0], timer_a_irq,
		adc_done_irq, can_port_irq, src_req[SRC_PIN_A]};

	// Per-source enable and level bits scattered over two register pairs
	assign en_all = {enable_t2_q, enable_prim_q};
	assign hi_all = {prio_t2_q, prio_prim_q};
	for (genvar s = 0; s < NUM_SRC; s++) begin : g_map
		assign en_src[s] = en_all[SRC_BIT[s]];
		assign hi_src[s] = hi_all[SRC_BIT[s]];
	end

	// Global allow bit and DMA blocking gate every source
	assign allow   = enable_prim_q[GLOBAL_ALLOW_BIT] & ~can_dma_busy;
	assign hi_pend = (allow & ~hi_active_q) ? (src_req & en_src & hi_src) : '0;
	assign lo_pend = (allow & ~hi_active_q & ~lo_active_q) ? (src_req & en_src & ~hi_src) : '0;

	// High level looked at first, then fixed order inside a level
	always_comb begin
		logic [4:0] h;
		logic [4:0] l;
		h = first_set(hi_pend);
		l = first_set(lo_pend);
		if (!h[4]) begin
			pick_idx   = h[3:0];
			pick_hi    = 1'b1;
			pick_valid = 1'b1;
		end else begin
			pick_idx   = l[3:0];
			pick_hi    = 1'b0;
			pick_valid = !l[4];
		end
	end

	// Candidate must stay stable for the least latency before the core sees it
	assign req  = cand_valid_q & (wait_q >= LAT_W'(LAT_MIN_CYC));
	assign take = req & cpu_irq_ack;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cand_idx_q   <= 4'h0;
			cand_hi_q    <= 1'b0;
			cand_valid_q <= 1'b0;
			wait_q       <= '0;
			vector_q     <= VEC_BASE;
		end else begin
			cand_idx_q   <= pick_idx;
			cand_hi_q    <= pick_hi;
			cand_valid_q <= pick_valid & ~take;
			vector_q     <= VEC_BASE + (16'(SRC_VEC[pick_valid ? pick_idx : 4'h0]) << VEC_SHIFT);
			if (take || !pick_valid || pick_idx != cand_idx_q || pick_hi != cand_hi_q) begin
				wait_q <= '0;
			end else if (wait_q != LAT_W'(LAT_MAX_CYC)) begin
				wait_q <= wait_q + LAT_W'(1);
			end
		end
	end

	// Waiting past the longest latency is flagged; write 1 clears, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			late_q <= 1'b0;
		end else if (req && !cpu_irq_ack && wait_q == LAT_W'(LAT_MAX_CYC - 1)) begin
			late_q <= 1'b1;
		end else if (wr_en && paddr == OFS_STATUS && pwdata[STAT_LATE]) begin
			late_q <= 1'b0;
		end
	end

	// In-service levels: set on vector take, released by return, deepest first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_active_q <= 1'b0;
			lo_active_q <= 1'b0;
		end else begin
			if (cpu_irq_return) begin
				if (hi_active_q) begin
					hi_active_q <= 1'b0;
				end else begin
					lo_active_q <= 1'b0;
				end
			end
			if (take && cand_hi_q) begin
				hi_active_q <= 1'b1;
			end
			if (take && !cand_hi_q) begin
				lo_active_q <= 1'b1;
			end
		end
	end

	// Pin-latched flags: edge sets, vector take of the source clears, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_flag_q <= 6'h00;
		end else begin
			for (int f = 0; f < 6; f++) begin
				if (take && flag_slot(cand_idx_q) == 3'(f)) begin
					pin_flag_q[f] <= 1'b0;
				end
				if (pin_evt[f] && (f < 2 ? pin_cfg_q[CFG_PIN_A_TRANS + f] : pin_cfg_q[CFG_CAP_PINS_IRQ])) begin
					pin_flag_q[f] <= 1'b1;
				end
			end
		end
	end

	// Idle ends only on enabled sources still alive in idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_wake_q <= 1'b0;
		end else begin
			idle_wake_q <= idle_mode & allow & (|(wake_req & en_src));
		end
	end

	assign idle_wake          = idle_wake_q;
	assign cpu_irq.req        = req;
	assign cpu_irq.high_level = cand_hi_q;
	assign cpu_irq.vector     = vector_q;

endmodule : two_level_irq_controller

// ==== verification/irq_ctrl_chk.sv ====
`timescale 1ns/1ns
module irq_ctrl_chk
	import irq_pkg::*;
(
	// Clock and reset
	input wire logic     pclk,
	input wire logic     presetn,
	// Bus answer
	input wire logic     psel,
	input wire logic     penable,
	input wire logic     pslverr,
	// System state
	input wire logic     can_dma_busy,
	input wire logic     idle_mode,
	input wire logic     idle_wake,
	// Core handshake
	input wire cpu_irq_t cpu_irq,
	input wire logic     cpu_irq_ack,
	input wire logic     cpu_irq_return
);
	logic hi_q;
	logic lo_q;
	logic took;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign took = cpu_irq.req && cpu_irq_ack;
	// Shadow of levels in service; a set on ack wins over a return
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_q <= 1'b0;
			lo_q <= 1'b0;
		end else begin
			if (cpu_irq_return && hi_q) hi_q <= 1'b0;
			else if (cpu_irq_return) lo_q <= 1'b0;
			if (took && cpu_irq.high_level) hi_q <= 1'b1;
			if (took && !cpu_irq.high_level) lo_q <= 1'b1;
		end
	end
	property p_err_phase; pslverr |-> psel && penable; endproperty
	a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
	property p_vec_grid; cpu_irq.req |-> cpu_irq.vector[2:0] == 3'h3 && cpu_irq.vector <= 16'h0073; endproperty
	a_vec_grid: assert property (p_vec_grid) else $error("vector off grid");
	property p_dma_block; can_dma_busy && $past(can_dma_busy) |-> !cpu_irq.req; endproperty
	a_dma_block: assert property (p_dma_block) else $error("request during dma");
	property p_wait; $rose(cpu_irq.req) |-> $past(cpu_irq.vector, 8) == cpu_irq.vector; endproperty
	a_wait: assert property (p_wait) else $error("request raised too soon");
	property p_ack_drop; took |-> ##[1:2] !cpu_irq.req; endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("request kept after ack");
	property p_hi_block; hi_q && $past(hi_q, 2) |-> !cpu_irq.req; endproperty
	a_hi_block: assert property (p_hi_block) else $error("high routine preempted");
	property p_lo_only_hi; lo_q && $past(lo_q, 2) && cpu_irq.req |-> cpu_irq.high_level; endproperty
	a_lo_only_hi: assert property (p_lo_only_hi) else $error("low routine preempted by low");
	property p_wake_idle; idle_wake |-> $past(idle_mode); endproperty
	a_wake_idle: assert property (p_wake_idle) else $error("wake while not idle");
	// Main scenarios reached
	c_high: cover property (took && cpu_irq.high_level);
	c_preempt: cover property (lo_q && took && cpu_irq.high_level);
	c_wake: cover property (idle_wake);
endmodule : irq_ctrl_chk
bind two_level_irq_controller irq_ctrl_chk irq_ctrl_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pslverr(pslverr), .can_dma_busy(can_dma_busy), .idle_mode(idle_mode),
	.idle_wake(idle_wake), .cpu_irq(cpu_irq), .cpu_irq_ack(cpu_irq_ack), .cpu_irq_return(cpu_irq_return));

// ==== verification/cpu_core_model.sv ====
`timescale 1ns/1ns
module cpu_core_model
	import irq_pkg::*;
(
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Controller side
	input  wire cpu_irq_t   cpu_irq,
	output logic            cpu_irq_ack,
	output logic            cpu_irq_return,
	// Bench control
	input  wire logic [3:0] ack_delay,
	input  wire logic       ret_go
);
	logic [15:0] wait_q;
	// One fetch per request, after a chosen delay; counter restarts when req falls
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_q      <= 16'h0000;
			cpu_irq_ack <= 1'b0;
		end else begin
			cpu_irq_ack <= cpu_irq.req && wait_q == {12'h000, ack_delay};
			wait_q      <= cpu_irq.req ? wait_q + 16'h0001 : 16'h0000;
		end
	end
	// Return from routine, one cycle after the bench asks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) cpu_irq_return <= 1'b0;
		else cpu_irq_return <= ret_go;
	end
endmodule : cpu_core_model

// ==== verification/two_level_irq_controller_tb_top.sv ====
`timescale 1ns/1ns
module two_level_irq_controller_tb_top
	import irq_pkg::*;
();
	logic        pclk;
	logic        presetn;
	logic [11:0] paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic [14:0] src;
	logic [3:0]  cap_pins;
	logic        can_dma_busy;
	logic        idle_mode;
	logic        idle_wake;
	cpu_irq_t    cpu_irq;
	logic        cpu_irq_ack;
	logic        cpu_irq_return;
	logic [3:0]  ack_delay;
	logic        ret_go;
	logic [31:0] rv;
	logic        re;
	int          err_count;
	int          checks;
	// Vectors and enable bits ({second, first} register) in service order
	logic [31:0] vec_tab [15] = '{32'h03, 32'h2B, 32'h53, 32'h0B, 32'h33, 32'h5B, 32'h13, 32'h3B,
		32'h63, 32'h1B, 32'h43, 32'h6B, 32'h23, 32'h4B, 32'h73};
	int          enb_tab [15] = '{0, 5, 6, 1, 8, 12, 2, 9, 13, 3, 10, 14, 4, 11, 15};
	two_level_irq_controller two_level_irq_controller_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .pin_irq_a_n(~src[0]), .pin_irq_b_n(~src[6]),
		.capture_input_pins(cap_pins), .timer_a_irq(src[3]), .timer_b_irq(src[9]),
		.capture_irq({src[13], src[10], src[7], src[4]}), .compare_irq({src[11], src[8], src[5]}),
		.timer_c_overflow_irq(src[14]), .adc_done_irq(src[2]), .can_port_irq(src[1]),
		.uart_port_irq(src[12]), .can_dma_busy(can_dma_busy), .idle_mode(idle_mode), .idle_wake(idle_wake),
		.cpu_irq(cpu_irq), .cpu_irq_ack(cpu_irq_ack), .cpu_irq_return(cpu_irq_return));
	cpu_core_model cpu_core_model_i (.pclk(pclk), .presetn(presetn), .cpu_irq(cpu_irq),
		.cpu_irq_ack(cpu_irq_ack), .cpu_irq_return(cpu_irq_return), .ack_delay(ack_delay), .ret_go(ret_go));
	// Free-running core clock
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task stop_test();
		$display("checks %0d, mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : stop_test
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check
	// Idle cycle after each transfer so psel is never assigned twice in one step
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			err_count++;
			stop_test();
		end
		@(posedge pclk);
	endtask : apb
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rv, re);
	endtask : wr
	task set_en(input logic [15:0] en, input logic [15:0] pr);
		wr(OFS_ENABLE_PRIMARY, {24'h0, en[7:0]});
		wr(OFS_ENABLE_T2, {24'h0, en[15:8]});
		wr(OFS_PRIO_PRIMARY, {24'h0, pr[7:0]});
		wr(OFS_PRIO_T2, {24'h0, pr[15:8]});
	endtask : set_en
	// Wait for a fetched vector; bit 16 of v is the level
	task take(output logic [31:0] v, output int n);
		n = 0;
		while (!(cpu_irq.req === 1'b1 && cpu_irq_ack === 1'b1) && n < 2000) begin
			@(posedge pclk);
			n++;
		end
		v = {15'h0, cpu_irq.high_level, cpu_irq.vector};
		if (n >= 2000) begin
			err_count++;
			stop_test();
		end
	endtask : take
	// Longer than the full request wait, so a blocked request would show
	task no_req(output int k);
		k = 0;
		repeat (400) begin
			@(posedge pclk);
			if (cpu_irq.req === 1'b1) k++;
		end
	endtask : no_req
	task ret();
		ret_go <= 1'b1;
		@(posedge pclk);
		ret_go <= 1'b0;
		@(posedge pclk);
	endtask : ret
	task automatic t_regs();
		int i;
		logic [11:0] ofs [4] = '{OFS_ENABLE_PRIMARY, OFS_ENABLE_T2, OFS_PRIO_PRIMARY, OFS_PRIO_T2};
		logic [31:0] wd [4] = '{32'hFF, 32'hA5, 32'hFF, 32'h5A};
		logic [31:0] ex [4] = '{32'hFF, 32'hA5, 32'h7F, 32'h5A};
		for (i = 0; i < 4; i++) begin
			apb(1'b0, ofs[i], 32'h0, rv, re);
			check(rv, 32'h0);
			wr(ofs[i], wd[i]);
			apb(1'b0, ofs[i], 32'h0, rv, re);
			check(rv, ex[i]);
		end
		wr(12'h100, 32'hFF);
		apb(1'b0, 12'h100, 32'h0, rv, re);
		check({rv[30:0], re}, 32'h1);
		set_en(16'h0, 16'h0);
		$display("register test done");
	endtask : t_regs
	task t_vec();
		int i;
		int n;
		logic [31:0] v;
		ack_delay <= 4'h0;
		for (i = 0; i < 15; i++) begin
			src[i] <= 1'b1;
			set_en(16'hFFFF ^ (16'h1 << enb_tab[i]), 16'h0);
			no_req(n);
			check(n, 0);
			// Source raised only once enabled, so the wait is timed from the request
			src[i] <= 1'b0;
			set_en(16'h0080 | (16'h1 << enb_tab[i]), 16'h0);
			src[i] <= 1'b1;
			take(v, n);
			check(v, vec_tab[i]);
			check(n >= LAT_MIN_CYC && n <= LAT_MAX_CYC, 1);
			src[i] <= 1'b0;
			ret();
		end
		$display("vector test done");
	endtask : t_vec
	task t_order();
		int i;
		int n;
		logic [31:0] v;
		ack_delay <= 4'h5;
		set_en(16'hFFFF, 16'h0);
		src <= 15'h7FFF;
		for (i = 0; i < 15; i++) begin
			take(v, n);
			check(v, vec_tab[i]);
			src[i] <= 1'b0;
			ret();
		end
		$display("order test done");
	endtask : t_order
	task t_nest();
		int n;
		logic [31:0] v;
		ack_delay <= 4'h2;
		set_en(16'hFFFF, 16'h000C);
		src <= 15'h4040; // Timer 2 overflow low, external 1 high
		take(v, n);
		check(v, 32'h0001_0013);
		src[6] <= 1'b0;
		no_req(n);
		check(n, 0);
		ret();
		take(v, n);
		check(v, 32'h0000_0073);
		src[12] <= 1'b1;
		no_req(n);
		check(n, 0);
		src[9] <= 1'b1;
		take(v, n);
		check(v, 32'h0001_001B);
		apb(1'b0, OFS_STATUS, 32'h0, rv, re);
		check(rv, 32'h0003_5200);
		src <= 15'h0;
		ret();
		ret();
		$display("nesting test done");
	endtask : t_nest
	task t_block();
		int n;
		logic [31:0] v;
		set_en(16'hFF7F, 16'h0);
		src[3] <= 1'b1;
		no_req(n);
		check(n, 0);
		can_dma_busy <= 1'b1;
		wr(OFS_ENABLE_PRIMARY, 32'hFF);
		no_req(n);
		check(n, 0);
		can_dma_busy <= 1'b0;
		take(v, n);
		check(v, 32'h0000_000B);
		src[3] <= 1'b0;
		ret();
		$display("blocking test done");
	endtask : t_block
	task t_pins();
		int n;
		logic [31:0] v;
		wr(OFS_PIN_CFG, 32'h95); // ext0 transition, pin 0 rising, pin 1 falling
		idle_mode <= 1'b1;
		cap_pins <= 4'h1;
		take(v, n);
		check(v, 32'h0000_0033);
		check(idle_wake, 1'b0);
		ret();
		src[0] <= 1'b1;
		repeat (4) @(posedge pclk);
		src[0] <= 1'b0;
		take(v, n);
		check(v, 32'h0000_0003);
		check(idle_wake, 1'b1);
		ret();
		cap_pins <= 4'h3;
		repeat (4) @(posedge pclk);
		cap_pins <= 4'h1;
		take(v, n);
		check(v, 32'h0000_003B);
		ret();
		idle_mode <= 1'b0;
		$display("pin test done");
	endtask : t_pins
	// Main sequence
	initial begin
		err_count = 0;
		checks = 0;
		presetn = 1'b0;
		paddr = 12'h000;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0;
		src = 15'h0;
		cap_pins = 4'h0;
		can_dma_busy = 1'b0;
		idle_mode = 1'b0;
		ack_delay = 4'h0;
		ret_go = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_vec();
		t_order();
		t_nest();
		t_block();
		t_pins();
		stop_test();
	end
endmodule : two_level_irq_controller_tb_top
